// ===== core/touch_probe_capture.sv
// dual touch probe position capture with status word
//
// What this block does
// (RL1) one 16-bit read-only status word, probe one low byte, probe two high byte
// (RL2) status bits 0 and 8 show whether each probe is enabled
// (RL3) status bits 1 and 9 show a rising-edge position is held
// (RL4) status bits 2 and 10 show a falling-edge position is held
// (RL5) status bits 6 and 14 show trigger source: digital input or index
// (RL6) status bits 7 and 15 mirror the live digital input level
// (RL7) with counting selected in continuous mode, top two bits show wrapping count
// (RL8) status bits 3 to 5 and 11 to 13 read zero
// (RL9) master enables a probe with control bit 0 or 8
// (RL10) control bit 1 or 9 picks single first-event or continuous capture
// (RL11) control bit 2 or 10 picks digital input or index as trigger
// (RL12) control bits 4,5 and 12,13 enable rising and falling edge sampling
// (RL13) each enabled edge in continuous mode, or the first one in single mode, latches the position, then sets its stored flag
module touch_probe_capture (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // process data from the master
   input wire logic [15:0] probeControlWord,
   input wire logic [15:0] probeCountModeSetting,
   // feedback position in reference units
   input wire logic signed [touch_probe_pkg::POS_WIDTH-1:0] feedbackPosition,
   // trigger pins
   input wire logic probeOneDigitalInput,
   input wire logic probeTwoDigitalInput,
   input wire logic encoderIndexPulse,
   // process data to the master
   output logic [15:0] probeStatusWord,
   output logic signed [touch_probe_pkg::POS_WIDTH-1:0] probeOneRisePosition,
   output logic signed [touch_probe_pkg::POS_WIDTH-1:0] probeOneFallPosition,
   output logic signed [touch_probe_pkg::POS_WIDTH-1:0] probeTwoRisePosition,
   output logic signed [touch_probe_pkg::POS_WIDTH-1:0] probeTwoFallPosition
);

   localparam int unsigned NP = touch_probe_pkg::PROBE_COUNT;
   localparam int unsigned BW = touch_probe_pkg::BYTE_WIDTH;

   touch_probe_pkg::capture_state_type st_q;
   touch_probe_pkg::capture_state_type st_d;

   logic [touch_probe_pkg::SYNC_WIDTH-1:0] pinLevel;
   logic [touch_probe_pkg::SYNC_WIDTH-1:0] syncLevel;
   touch_probe_pkg::probe_ctrl_type ctrl [NP];
   logic inputLevel [NP];
   logic trigLevel [NP];
   logic armed [NP];
   logic riseHit [NP];
   logic fallHit [NP];
   logic countActive;

   // pins gathered into synchroniser lanes
   assign pinLevel = {encoderIndexPulse, probeTwoDigitalInput, probeOneDigitalInput};

   sync_bank u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pinLevel(pinLevel),
      .syncLevel(syncLevel)
   );

   // counting needs the vendor setting
   assign countActive = (probeCountModeSetting == touch_probe_pkg::COUNT_MODE_VALUE); // RL7

   // per-probe decode, trigger selection and event detection
   for (genvar g = 0; g < NP; g++) begin : g_probe
      // control byte of this probe
      assign ctrl[g] = touch_probe_pkg::decode_ctrl(probeControlWord[g*BW +: BW]); // RL9
      assign inputLevel[g] = syncLevel[g];
      // source select between own input and index pulse
      assign trigLevel[g] = ctrl[g].indexSource ? syncLevel[touch_probe_pkg::SYNC_INDEX] : syncLevel[g]; // RL11
      // armed only once enable has settled and source is steady, so a switch makes no false edge
      assign armed[g] = ctrl[g].enable && st_q.chan[g].enablePrev
                        && (ctrl[g].indexSource == st_q.chan[g].sourcePrev);
      // edge hits: single mode takes only the first per edge
      assign riseHit[g] = armed[g] && ctrl[g].riseEnable && trigLevel[g] && !st_q.chan[g].trigPrev
                          && (ctrl[g].continuous || !st_q.chan[g].riseStored); // RL10 RL12
      assign fallHit[g] = armed[g] && ctrl[g].fallEnable && !trigLevel[g] && st_q.chan[g].trigPrev
                          && (ctrl[g].continuous || !st_q.chan[g].fallStored); // RL10 RL12
   end

   // next state of both probes and the status word
   always_comb begin
      st_d = st_q;
      for (int i = 0; i < NP; i++) begin
         st_d.chan[i].enablePrev = ctrl[i].enable;
         st_d.chan[i].trigPrev = trigLevel[i];
         st_d.chan[i].sourcePrev = ctrl[i].indexSource;
         // fresh arming drops old results
         if (ctrl[i].enable && !st_q.chan[i].enablePrev) begin
            st_d.chan[i].riseStored = 1'b0;
            st_d.chan[i].fallStored = 1'b0;
            st_d.chan[i].execCount = '0;
         end
         // flags fall when the probe or its edge is off
         if (!ctrl[i].enable || !ctrl[i].riseEnable) begin
            st_d.chan[i].riseStored = 1'b0; // RL3
         end
         if (!ctrl[i].enable || !ctrl[i].fallEnable) begin
            st_d.chan[i].fallStored = 1'b0; // RL4
         end
         // latch position, then flag it
         if (riseHit[i]) begin
            st_d.chan[i].risePos = feedbackPosition; // RL13
            st_d.chan[i].riseStored = 1'b1; // RL3
         end
         if (fallHit[i]) begin
            st_d.chan[i].fallPos = feedbackPosition; // RL13
            st_d.chan[i].fallStored = 1'b1; // RL4
         end
         // execution count wraps through 0 to 3
         if ((riseHit[i] || fallHit[i]) && ctrl[i].continuous) begin
            st_d.chan[i].execCount = st_q.chan[i].execCount + touch_probe_pkg::COUNT_STEP; // RL7
         end
         // status byte of this probe, unused bits zero
         st_d.statusWord[i*BW +: BW] = '0; // RL1 RL8
         st_d.statusWord[i*BW + touch_probe_pkg::ST_ENABLE] = ctrl[i].enable; // RL2
         st_d.statusWord[i*BW + touch_probe_pkg::ST_RISE] = st_d.chan[i].riseStored; // RL3
         st_d.statusWord[i*BW + touch_probe_pkg::ST_FALL] = st_d.chan[i].fallStored; // RL4
         if (countActive && ctrl[i].continuous) begin
            st_d.statusWord[i*BW + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH] =
               st_d.chan[i].execCount; // RL7
         end else begin
            st_d.statusWord[i*BW + touch_probe_pkg::ST_SOURCE] = ctrl[i].indexSource; // RL5
            st_d.statusWord[i*BW + touch_probe_pkg::ST_LEVEL] = inputLevel[i]; // RL6
         end
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= touch_probe_pkg::CAPTURE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign probeStatusWord = st_q.statusWord; // RL1
   assign probeOneRisePosition = st_q.chan[0].risePos;
   assign probeOneFallPosition = st_q.chan[0].fallPos;
   assign probeTwoRisePosition = st_q.chan[1].risePos;
   assign probeTwoFallPosition = st_q.chan[1].fallPos;

   // checks per probe
   for (genvar a = 0; a < NP; a++) begin : g_check
      localparam int unsigned B = a * BW;

      // enable bit follows control one cycle later
      a_enable_bit_follows: assert property (@(posedge mclk) disable iff (sys_rst) // RL2
         ##1 probeStatusWord[B + touch_probe_pkg::ST_ENABLE] == $past(ctrl[a].enable))
         else $error("status enable bit does not follow control");

      // unused bits stay zero
      a_unused_bits_zero: assert property (@(posedge mclk) disable iff (sys_rst) // RL8
         probeStatusWord[B + touch_probe_pkg::ST_UNUSED_LSB +: touch_probe_pkg::ST_UNUSED_WIDTH] == '0)
         else $error("unused status bits not zero");

      // switched off probe shows nothing stored
      a_disable_clears_flags: assert property (@(posedge mclk) disable iff (sys_rst) // RL3
         !ctrl[a].enable |=> !probeStatusWord[B + touch_probe_pkg::ST_RISE]
                             && !probeStatusWord[B + touch_probe_pkg::ST_FALL]
                             && !probeStatusWord[B + touch_probe_pkg::ST_ENABLE])
         else $error("flags held while probe off");

      // rising edge latches the position and sets the flag
      a_rise_capture_value: assert property (@(posedge mclk) disable iff (sys_rst) // RL13
         ctrl[a].enable && $past(ctrl[a].enable) && $stable(ctrl[a].indexSource)
         && ctrl[a].riseEnable && $rose(trigLevel[a])
         && (ctrl[a].continuous || !probeStatusWord[B + touch_probe_pkg::ST_RISE])
         |=> (a == 0 ? probeOneRisePosition : probeTwoRisePosition) == $past(feedbackPosition)
             && probeStatusWord[B + touch_probe_pkg::ST_RISE])
         else $error("rising edge capture missed");

      // falling edge latches the position and sets the flag
      a_fall_capture_value: assert property (@(posedge mclk) disable iff (sys_rst) // RL13
         ctrl[a].enable && $past(ctrl[a].enable) && $stable(ctrl[a].indexSource)
         && ctrl[a].fallEnable && $fell(trigLevel[a])
         && (ctrl[a].continuous || !probeStatusWord[B + touch_probe_pkg::ST_FALL])
         |=> (a == 0 ? probeOneFallPosition : probeTwoFallPosition) == $past(feedbackPosition)
             && probeStatusWord[B + touch_probe_pkg::ST_FALL])
         else $error("falling edge capture missed");

      // single mode keeps the first rising value
      a_single_keeps_first: assert property (@(posedge mclk) disable iff (sys_rst) // RL10
         !ctrl[a].continuous && probeStatusWord[B + touch_probe_pkg::ST_RISE] && ctrl[a].riseEnable
         |=> $stable(a == 0 ? probeOneRisePosition : probeTwoRisePosition))
         else $error("single mode overwrote first value");

      // no capture while the falling edge is switched off
      a_edge_off_holds: assert property (@(posedge mclk) disable iff (sys_rst) // RL12
         !ctrl[a].fallEnable |=> $stable(a == 0 ? probeOneFallPosition : probeTwoFallPosition))
         else $error("capture with edge disabled");

      // source bit reports the selected trigger
      a_source_reported: assert property (@(posedge mclk) disable iff (sys_rst) // RL5
         !(countActive && ctrl[a].continuous)
         |=> probeStatusWord[B + touch_probe_pkg::ST_SOURCE] == $past(ctrl[a].indexSource))
         else $error("source bit wrong");

      // level bit mirrors the digital input
      a_level_mirrors: assert property (@(posedge mclk) disable iff (sys_rst) // RL6
         !(countActive && ctrl[a].continuous)
         |=> probeStatusWord[B + touch_probe_pkg::ST_LEVEL] == $past(inputLevel[a]))
         else $error("level bit does not mirror input");

      // count steps by one per captured event and wraps
      a_count_wraps: assert property (@(posedge mclk) disable iff (sys_rst) // RL7
         $past(countActive && ctrl[a].continuous) && countActive && ctrl[a].continuous
         && (riseHit[a] || fallHit[a])
         |=> probeStatusWord[B + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH]
             == 2'($past(probeStatusWord[B + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH])
             + touch_probe_pkg::COUNT_STEP))
         else $error("execution count did not step");

      // rising flag drops while its edge is switched off
      a_rise_flag_off: assert property (@(posedge mclk) disable iff (sys_rst) // RL3
         !ctrl[a].riseEnable |=> !probeStatusWord[B + touch_probe_pkg::ST_RISE])
         else $error("rising flag held with edge off");

      // falling flag drops while its edge is switched off
      a_fall_flag_off: assert property (@(posedge mclk) disable iff (sys_rst) // RL4
         !ctrl[a].fallEnable |=> !probeStatusWord[B + touch_probe_pkg::ST_FALL])
         else $error("falling flag held with edge off");

      // rising flag is only raised by a capture
      a_rise_flag_cause: assert property (@(posedge mclk) disable iff (sys_rst) // RL3
         !probeStatusWord[B + touch_probe_pkg::ST_RISE] && !riseHit[a]
         |=> !probeStatusWord[B + touch_probe_pkg::ST_RISE])
         else $error("rising flag set without capture");

      // falling flag is only raised by a capture
      a_fall_flag_cause: assert property (@(posedge mclk) disable iff (sys_rst) // RL4
         !probeStatusWord[B + touch_probe_pkg::ST_FALL] && !fallHit[a]
         |=> !probeStatusWord[B + touch_probe_pkg::ST_FALL])
         else $error("falling flag set without capture");

      // a held rising flag stays while probe and edge stay on
      a_rise_flag_stays: assert property (@(posedge mclk) disable iff (sys_rst) // RL3
         probeStatusWord[B + touch_probe_pkg::ST_RISE] && ctrl[a].enable && ctrl[a].riseEnable
         |=> probeStatusWord[B + touch_probe_pkg::ST_RISE])
         else $error("rising flag lost");

      // a held falling flag stays while probe and edge stay on
      a_fall_flag_stays: assert property (@(posedge mclk) disable iff (sys_rst) // RL4
         probeStatusWord[B + touch_probe_pkg::ST_FALL] && ctrl[a].enable && ctrl[a].fallEnable
         |=> probeStatusWord[B + touch_probe_pkg::ST_FALL])
         else $error("falling flag lost");

      // rising position moves only on a rising capture
      a_rise_pos_steady: assert property (@(posedge mclk) disable iff (sys_rst) // RL13
         !riseHit[a] |=> $stable(a == 0 ? probeOneRisePosition : probeTwoRisePosition))
         else $error("rising position changed without capture");

      // falling position moves only on a falling capture
      a_fall_pos_steady: assert property (@(posedge mclk) disable iff (sys_rst) // RL13
         !fallHit[a] |=> $stable(a == 0 ? probeOneFallPosition : probeTwoFallPosition))
         else $error("falling position changed without capture");

      // rising position untouched while its edge is off
      a_rise_edge_holds: assert property (@(posedge mclk) disable iff (sys_rst) // RL12
         !ctrl[a].riseEnable |=> $stable(a == 0 ? probeOneRisePosition : probeTwoRisePosition))
         else $error("rising capture with edge disabled");

      // single mode keeps the first falling value
      a_single_keeps_fall: assert property (@(posedge mclk) disable iff (sys_rst) // RL10
         !ctrl[a].continuous && probeStatusWord[B + touch_probe_pkg::ST_FALL] && ctrl[a].fallEnable
         |=> $stable(a == 0 ? probeOneFallPosition : probeTwoFallPosition))
         else $error("single mode overwrote first falling value");

      // switched off probe captures nothing
      a_off_no_capture: assert property (@(posedge mclk) disable iff (sys_rst) // RL13
         !ctrl[a].enable |=> $stable(a == 0 ? probeOneRisePosition : probeTwoRisePosition)
                             && $stable(a == 0 ? probeOneFallPosition : probeTwoFallPosition))
         else $error("capture while probe off");

      // a source switch blocks capture for that cycle
      a_source_switch_blocks: assert property (@(posedge mclk) disable iff (sys_rst) // RL11
         $changed(ctrl[a].indexSource) |=> $stable(a == 0 ? probeOneRisePosition : probeTwoRisePosition)
                                           && $stable(a == 0 ? probeOneFallPosition : probeTwoFallPosition))
         else $error("capture on a source switch");

      // arming restarts the shown count at zero
      a_arm_clears_count: assert property (@(posedge mclk) disable iff (sys_rst) // RL7
         countActive && ctrl[a].continuous && ctrl[a].enable && !$past(ctrl[a].enable)
         |=> probeStatusWord[B + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH] == '0)
         else $error("count not cleared on arming");

      // without a capture the shown count holds
      a_count_holds: assert property (@(posedge mclk) disable iff (sys_rst) // RL7
         $past(countActive && ctrl[a].continuous) && countActive && ctrl[a].continuous
         && ctrl[a].enable && $past(ctrl[a].enable) && !riseHit[a] && !fallHit[a]
         |=> probeStatusWord[B + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH]
             == $past(probeStatusWord[B + touch_probe_pkg::ST_COUNT_LSB +: touch_probe_pkg::COUNT_WIDTH]))
         else $error("execution count moved without capture");
   end

   // byte lanes are not swapped between the probes
   a_status_layout: assert property (@(posedge mclk) disable iff (sys_rst) // RL1
      ##1 probeStatusWord[BW + touch_probe_pkg::ST_ENABLE] == $past(probeControlWord[BW + touch_probe_pkg::CTL_ENABLE])
      && probeStatusWord[touch_probe_pkg::ST_ENABLE] == $past(probeControlWord[touch_probe_pkg::CTL_ENABLE]))
      else $error("status byte lanes swapped");

endmodule : touch_probe_capture

// ===== core/touch_probe_pkg.sv
// shared constants, field layouts and types of the touch probe capture unit
package touch_probe_pkg;

   // widths and counts
   localparam int unsigned POS_WIDTH = 32;
   localparam int unsigned PROBE_COUNT = 2;
   localparam int unsigned BYTE_WIDTH = 8;
   localparam int unsigned SYNC_WIDTH = 3;
   localparam int unsigned COUNT_WIDTH = 2;

   // object indices of the read-only process data words
   localparam logic [15:0] STATUS_WORD_INDEX = 16'h60b9;
   localparam logic [15:0] ONE_RISE_INDEX = 16'h60ba;
   localparam logic [15:0] ONE_FALL_INDEX = 16'h60bb;
   localparam logic [15:0] TWO_RISE_INDEX = 16'h60bc;
   localparam logic [15:0] TWO_FALL_INDEX = 16'h60bd;

   // field positions inside one probe byte of the control word
   localparam int unsigned CTL_ENABLE = 0;
   localparam int unsigned CTL_CONTINUOUS = 1;
   localparam int unsigned CTL_SOURCE = 2;
   localparam int unsigned CTL_RISE = 4;
   localparam int unsigned CTL_FALL = 5;

   // field positions inside one probe byte of the status word
   localparam int unsigned ST_ENABLE = 0;
   localparam int unsigned ST_RISE = 1;
   localparam int unsigned ST_FALL = 2;
   localparam int unsigned ST_UNUSED_LSB = 3;
   localparam int unsigned ST_UNUSED_WIDTH = 3;
   localparam int unsigned ST_SOURCE = 6;
   localparam int unsigned ST_LEVEL = 7;
   localparam int unsigned ST_COUNT_LSB = 6;

   // synchroniser lanes: probe inputs on 0 and 1, encoder index on 2
   localparam int unsigned SYNC_INDEX = 2;

   // count mode setting value that turns on the execution count
   localparam logic [15:0] COUNT_MODE_VALUE = 16'h0002;
   localparam logic [COUNT_WIDTH-1:0] COUNT_STEP = 2'h1;

   // decoded control fields of one probe
   typedef struct packed {
      logic fallEnable;
      logic riseEnable;
      logic indexSource;
      logic continuous;
      logic enable;
   } probe_ctrl_type;

   // per-probe capture state
   typedef struct packed {
      logic enablePrev;
      logic trigPrev;
      logic sourcePrev;
      logic riseStored;
      logic fallStored;
      logic [COUNT_WIDTH-1:0] execCount;
      logic [POS_WIDTH-1:0] risePos;
      logic [POS_WIDTH-1:0] fallPos;
   } chan_state_type;

   // whole state of the capture unit
   typedef struct packed {
      chan_state_type [PROBE_COUNT-1:0] chan;
      logic [15:0] statusWord;
   } capture_state_type;

   // two-stage synchroniser state
   typedef struct packed {
      logic [SYNC_WIDTH-1:0] stage1;
      logic [SYNC_WIDTH-1:0] stage2;
   } sync_state_type;

   // reset values
   localparam capture_state_type CAPTURE_RESET = '0;
   localparam sync_state_type SYNC_RESET = '0;

   // splits one control byte into its fields
   function automatic probe_ctrl_type decode_ctrl(input logic [BYTE_WIDTH-1:0] ctl);
      probe_ctrl_type c;
      c.enable = ctl[CTL_ENABLE];
      c.continuous = ctl[CTL_CONTINUOUS];
      c.indexSource = ctl[CTL_SOURCE];
      c.riseEnable = ctl[CTL_RISE];
      c.fallEnable = ctl[CTL_FALL];
      return c;
   endfunction : decode_ctrl

endpackage : touch_probe_pkg

// ===== core/sync_bank.sv
// two flip-flop synchroniser for the probe and index pins
module sync_bank (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // asynchronous pins
   input wire logic [touch_probe_pkg::SYNC_WIDTH-1:0] pinLevel,
   // levels on the mclk domain
   output logic [touch_probe_pkg::SYNC_WIDTH-1:0] syncLevel
);

   touch_probe_pkg::sync_state_type st_q;
   touch_probe_pkg::sync_state_type st_d;

   // first stage is read only by the second
   always_comb begin
      st_d.stage1 = pinLevel;
      st_d.stage2 = st_q.stage1;
   end

   // state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= touch_probe_pkg::SYNC_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign syncLevel = st_q.stage2;

endmodule : sync_bank

// ===== tb/fieldbus_master_model.sv
// fieldbus master model that writes the probe control and count mode objects
module fieldbus_master_model (
   // clock
   input wire logic mclk,
   // process data to the drive
   output logic [15:0] probeControlWord,
   output logic [15:0] probeCountModeSetting
);
   timeunit 1ns;
   timeprecision 100ps;

   // both probes off and counting off after power-up
   initial begin
      probeControlWord = 16'h0000;
      probeCountModeSetting = 16'h0000;
   end

   // builds one probe byte of the control word, spare bits kept zero
   function automatic logic [7:0] probe_byte(input logic en, input logic cont, input logic idx,
      input logic rise, input logic fall);
      return {2'b00, fall, rise, 1'b0, idx, cont, en};
   endfunction : probe_byte

   // writes the whole control word just after a rising edge, held until the next write
   task automatic put_ctrl(input logic [7:0] two, input logic [7:0] one);
      @(posedge mclk);
      probeControlWord <= {two, one};
   endtask : put_ctrl

   // writes the vendor count mode setting
   task automatic put_mode(input logic [15:0] value);
      @(posedge mclk);
      probeCountModeSetting <= value;
   endtask : put_mode
endmodule : fieldbus_master_model

// ===== tb/tb_touch_probe_capture.sv
// self-checking bench of the touch probe capture unit
module tb_touch_probe_capture;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk;
   logic sys_rst;
   logic [15:0] probeControlWord;
   logic [15:0] probeCountModeSetting;
   logic signed [31:0] feedbackPosition;
   logic probeOneDigitalInput;
   logic probeTwoDigitalInput;
   logic encoderIndexPulse;
   logic [15:0] probeStatusWord;
   logic signed [31:0] probeOneRisePosition;
   logic signed [31:0] probeOneFallPosition;
   logic signed [31:0] probeTwoRisePosition;
   logic signed [31:0] probeTwoFallPosition;
   logic [31:0] statAll;
   logic [31:0] statLo;
   logic [31:0] statHi;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;

   // status views widened for the compare task
   assign statAll = {16'h0000, probeStatusWord};
   assign statLo = {24'h000000, probeStatusWord[7:0]};
   assign statHi = {24'h000000, probeStatusWord[15:8]};

   fieldbus_master_model master (
      .mclk(mclk),
      .probeControlWord(probeControlWord),
      .probeCountModeSetting(probeCountModeSetting)
   );

   touch_probe_capture uut (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .probeControlWord(probeControlWord),
      .probeCountModeSetting(probeCountModeSetting),
      .feedbackPosition(feedbackPosition),
      .probeOneDigitalInput(probeOneDigitalInput),
      .probeTwoDigitalInput(probeTwoDigitalInput),
      .encoderIndexPulse(encoderIndexPulse),
      .probeStatusWord(probeStatusWord),
      .probeOneRisePosition(probeOneRisePosition),
      .probeOneFallPosition(probeOneFallPosition),
      .probeTwoRisePosition(probeTwoRisePosition),
      .probeTwoFallPosition(probeTwoFallPosition)
   );

   // 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // prints the verdict and ends the run
   task automatic close_out();
      if (n_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // compares one value and reports a mismatch
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // lets n edges pass, then settles at the falling edge for sampling
   task automatic wait_cy(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : wait_cy

   // cuts a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         n_errors++;
         close_out();
      end
   end

   // main sequence
   initial begin
      sys_rst = 1'b1;
      feedbackPosition = 32'h00000000;
      probeOneDigitalInput = 1'b0;
      probeTwoDigitalInput = 1'b0;
      encoderIndexPulse = 1'b0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      wait_cy(1);
      chk(statAll, 32'h00000000);
      chk(probeOneRisePosition, 32'h00000000);
      // probe one single mode, digital input, both edges
      master.put_ctrl(8'h00, master.probe_byte(1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
      wait_cy(3);
      chk(statAll, 32'h00000001);
      @(posedge mclk);
      feedbackPosition <= 32'h11111111;
      probeOneDigitalInput <= 1'b1;
      wait_cy(5);
      chk(probeOneRisePosition, 32'h11111111);
      chk(statAll, 32'h00000083);
      @(posedge mclk);
      feedbackPosition <= 32'h22222222;
      probeOneDigitalInput <= 1'b0;
      wait_cy(5);
      chk(probeOneFallPosition, 32'h22222222);
      chk(statAll, 32'h00000007);
      // second rising edge ignored in single mode
      @(posedge mclk);
      feedbackPosition <= 32'h33333333;
      probeOneDigitalInput <= 1'b1;
      wait_cy(5);
      chk(probeOneRisePosition, 32'h11111111);
      // probe two continuous on the index pulse with counting shown
      master.put_mode(touch_probe_pkg::COUNT_MODE_VALUE);
      master.put_ctrl(master.probe_byte(1'b1, 1'b1, 1'b1, 1'b1, 1'b0), probeControlWord[7:0]);
      wait_cy(3);
      chk(statHi, 32'h00000001);
      for (int i = 1; i <= 5; i++) begin
         @(posedge mclk);
         feedbackPosition <= 32'h40000000 + 32'(i);
         encoderIndexPulse <= 1'b1;
         wait_cy(5);
         chk(probeTwoRisePosition, 32'h40000000 + 32'(i));
         chk(statHi, {24'h000000, 2'(i), 6'h03});
         @(posedge mclk);
         encoderIndexPulse <= 1'b0;
         wait_cy(3);
      end
      chk(statLo, 32'h00000087);
      chk(probeTwoFallPosition, 32'h00000000);
      // counting off: source and level bits come back
      master.put_mode(16'h0000);
      wait_cy(2);
      chk(statHi, 32'h00000043);
      @(posedge mclk);
      probeTwoDigitalInput <= 1'b1;
      wait_cy(5);
      chk(statHi, 32'h000000c3);
      chk(probeTwoRisePosition, 32'h40000005);
      // probe two falling edge switched on, signed value captured
      master.put_ctrl(master.probe_byte(1'b1, 1'b1, 1'b1, 1'b1, 1'b1), probeControlWord[7:0]);
      @(posedge mclk);
      feedbackPosition <= 32'h50000000;
      encoderIndexPulse <= 1'b1;
      wait_cy(5);
      chk(probeTwoRisePosition, 32'h50000000);
      @(posedge mclk);
      feedbackPosition <= 32'ha0000000;
      encoderIndexPulse <= 1'b0;
      wait_cy(5);
      chk(probeTwoFallPosition, 32'ha0000000);
      chk(statHi, 32'h000000c7);
      // probe one switched off: flags drop, rising position stays
      master.put_ctrl(probeControlWord[15:8], 8'h00);
      wait_cy(3);
      chk(statLo, 32'h00000080);
      chk(probeOneRisePosition, 32'h11111111);
      close_out();
   end
endmodule : tb_touch_probe_capture
